// ==== hdl/rit_pkg.sv ====
// ============================================================
// shared constants for the rom / port / timer host block
// ============================================================
package rit_pkg;
   // register select codes on the three low address lines
   localparam logic [2:0] SEL_STATUS_A = 3'h0; // combined status
   localparam logic [2:0] SEL_PCTL     = 3'h1; // port control
   localparam logic [2:0] SEL_DDIR     = 3'h2; // data direction
   localparam logic [2:0] SEL_PDATA    = 3'h3; // peripheral data
   localparam logic [2:0] SEL_STATUS_B = 3'h4; // combined status alias
   localparam logic [2:0] SEL_TCTL     = 3'h5; // timer control
   localparam logic [2:0] SEL_TMSB     = 3'h6; // timer high byte
   localparam logic [2:0] SEL_TLSB     = 3'h7; // timer low byte
   // reset values
   localparam logic [7:0]  PCTL_RST  = 8'h80; // port held in reset
   localparam logic [7:0]  TCTL_RST  = 8'h01; // timer held in reset
   localparam logic [15:0] LATCH_RST = 16'hFFFF; // maximum count
   // field positions
   localparam int PCTL_HOLD   = 7; // port reset hold bit
   localparam int PCTL_LATCH  = 4; // latched input enable
   localparam int PCTL_C2OUT  = 5; // control line is an output
   localparam int PCTL_C2LVL  = 3; // control line output level
   localparam int PCTL_C2EDGE = 2; // control line rising edge select
   localparam int PCTL_S1EDGE = 1; // strobe rising edge select
   localparam int PCTL_S1IEN  = 0; // strobe interrupt enable
   localparam int TCTL_SRST   = 0; // timer soft reset bit
   localparam int TCTL_EXTCLK = 1; // external clock source
   localparam int TCTL_PRE8   = 2; // divide-by-8 prescaler
   localparam int TCTL_GATED  = 3; // gate input gates the clock
   localparam int TCTL_IEN    = 6; // timer interrupt enable
   localparam int TCTL_OEN    = 7; // timer output enable
   // synchroniser depth in strobe periods before recognition
   localparam int SYNC_STAGES = 3;
   localparam logic [2:0] PRE_LAST = 3'h7; // prescaler terminal count
endpackage : rit_pkg

// ==== hdl/rit_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 2048-byte rom addressed by eleven lines
// - data drivers on only during selected reads
// - write latches bus, read drives bus
// - low three bits pick register, upper qualify
// - fixed select polarities split rom and registers
// - reset initialises every port and timer bit
// - strobe samples timer clock, gate inputs
// - interrupt output only ever pulls low
// - direction bit per line, inputs undriven
// - reset clears direction, all lines inputs
// - strobe input edge sets its flag
// - latched mode captures lines on strobe
// - control line is interrupt input or output
// - three stages sync, fourth strobe decrements
// - late transition seen one strobe later
// - timer control picks irq, output, clock, prescale
// - gate input triggers or gates counter
// - timer output follows control, gate, clock
// - address map, status read-only
// - port hold bit set by reset, cleared by software
// - reset presets latches, soft reset keeps them
module rit_top #(
   parameter logic [1:0] ROM_SEL = 2'h1,  // select pattern for rom
   parameter logic [1:0] IO_SEL  = 2'h2,  // select pattern for registers
   parameter logic [7:0] UPPER_Q = 8'h00  // required upper address bits
)(
   input  wire logic        CLOCK,           // 50 MHz system clock
   input  wire logic        ARST_N,          // async reset, active low
   input  wire logic        BUS_STROBE,      // bus phase strobe pin
   input  wire logic        VALID_MEMORY_ACCESS, // host cycle qualifier
   input  wire logic        READ_NOT_WRITE,  // high read, low write
   input  wire logic        SELECT_INPUT_ZERO, // chip select 0
   input  wire logic        SELECT_INPUT_ONE,  // chip select 1
   input  wire logic [10:0] HOST_ADDRESS_LINES, // host address
   input  wire logic [7:0]  HOST_DATA_LINES_IN, // host data sensed
   output logic      [7:0]  HOST_DATA_LINES_OUT, // host data driven
   output logic             HOST_DATA_LINES_OE,  // high while driving
   output logic             IRQ_N_OE,        // pulls request line low
   input  wire logic [7:0]  PERIPHERAL_LINES_IN,  // port pins sensed
   output logic      [7:0]  PERIPHERAL_LINES_OUT, // port pins driven
   output logic      [7:0]  PERIPHERAL_LINES_OE,  // per-line enables
   input  wire logic        PORT_STROBE_INPUT,    // input-only strobe
   input  wire logic        PORT_CONTROL_LINE_IN, // control line sensed
   output logic             PORT_CONTROL_LINE_OUT, // control line driven
   output logic             PORT_CONTROL_LINE_OE,  // control line enable
   input  wire logic        TIMER_EXTERNAL_CLOCK,  // external count clock
   input  wire logic        TIMER_GATE_INPUT,      // gate / trigger
   output logic             TIMER_OUTPUT_PIN       // timer output
);
   // ============================================================
   // pin synchronisers
   // ============================================================
   // two flops on every asynchronous pin except address and host data; the first flop feeds only the second
   logic [16:0] s1_r;  // first stage
   logic [16:0] s2_r;  // second stage, safe to read
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         s1_r <= 17'h00000;
         s2_r <= 17'h00000;
      end
      else
      begin
         s1_r <= {BUS_STROBE, VALID_MEMORY_ACCESS, READ_NOT_WRITE, SELECT_INPUT_ONE,
                  SELECT_INPUT_ZERO, PORT_STROBE_INPUT, PORT_CONTROL_LINE_IN,
                  TIMER_EXTERNAL_CLOCK, TIMER_GATE_INPUT, PERIPHERAL_LINES_IN};
         s2_r <= s1_r;
      end
   end
   logic e_s, vma_s, rw_s, cs1_s, cs0_s, stb_s, ctl_s, ctc_s, ctg_s;
   logic [7:0] pin_s;  // synchronised port lines
   assign {e_s, vma_s, rw_s, cs1_s, cs0_s, stb_s, ctl_s, ctc_s, ctg_s, pin_s} = s2_r;
   // host data is sampled only at the strobe fall and the address feeds the decode and read mux directly; they
   // are stable by then per bus setup time, so no extra flops are spent
   logic e_d_r;  // strobe delayed, for edge detect
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         e_d_r <= 1'b0;
      else
         e_d_r <= e_s;
   end
   logic e_fall;  // strobe falling edge pulse
   logic e_rise;  // strobe rising edge pulse
   assign e_fall = e_d_r & ~e_s;
   assign e_rise = ~e_d_r & e_s;
   // equal select patterns would let rom and registers fight for the bus
   if (ROM_SEL == IO_SEL)
   begin : g_sel_clash
      $error("rom and register select patterns are equal");
   end
   // ============================================================
   // select decode
   // ============================================================
   logic rom_sel, io_sel;  // function selects
   assign rom_sel = vma_s && ({cs1_s, cs0_s} == ROM_SEL);
   assign io_sel  = vma_s && ({cs1_s, cs0_s} == IO_SEL)
                    && (HOST_ADDRESS_LINES[10:3] == UPPER_Q);
   logic [2:0] rsel;
   assign rsel = HOST_ADDRESS_LINES[2:0];
   logic wr_cyc;  // selected register write at strobe fall
   assign wr_cyc = e_fall && io_sel && !rw_s;
   // ============================================================
   // rom array
   // ============================================================
   // contents stand for the mask pattern; zero until customised
   logic [7:0] rom_mem [0:2047];
   initial
   begin
      for (int i = 0; i < 2048; i++)
         rom_mem[i] = 8'h00;
   end
   logic [7:0] rom_q;
   assign rom_q = rom_mem[HOST_ADDRESS_LINES];
   // ============================================================
   // port registers
   // ============================================================
   logic [7:0] pctl_r, ddir_r, pdata_r;  // control, direction, data
   logic stb_d_r, ctl_d_r;  // edge detect history
   logic flag1_r, flag2_r;  // port interrupt flags
   logic stb_edge, ctl_edge;
   assign stb_edge = pctl_r[rit_pkg::PCTL_S1EDGE] ? (stb_s & ~stb_d_r) : (~stb_s & stb_d_r);
   assign ctl_edge = pctl_r[rit_pkg::PCTL_C2EDGE] ? (ctl_s & ~ctl_d_r) : (~ctl_s & ctl_d_r);
   logic port_live;
   assign port_live = !pctl_r[rit_pkg::PCTL_HOLD];
   logic stat_rd;  // status read clears port flags
   assign stat_rd = e_fall && io_sel && rw_s
                    && (rsel == rit_pkg::SEL_STATUS_A || rsel == rit_pkg::SEL_STATUS_B);

   // register writes
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pctl_r <= rit_pkg::PCTL_RST;
         ddir_r <= 8'h00;
      end
      else if (wr_cyc)
      begin
         if (rsel == rit_pkg::SEL_PCTL)
            pctl_r <= HOST_DATA_LINES_IN;
         if (rsel == rit_pkg::SEL_DDIR)
            ddir_r <= HOST_DATA_LINES_IN;
      end
   end

   // data register: written by host or latched by strobe edge
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         pdata_r <= 8'h00;
      else if (port_live && pctl_r[rit_pkg::PCTL_LATCH] && stb_edge)
         pdata_r <= pin_s;
      else if (wr_cyc && rsel == rit_pkg::SEL_PDATA)
         pdata_r <= HOST_DATA_LINES_IN;
   end

   // port interrupt flags; a new edge wins over a status read clear
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         stb_d_r <= 1'b0;
         ctl_d_r <= 1'b0;
         flag1_r <= 1'b0;
         flag2_r <= 1'b0;
      end
      else
      begin
         stb_d_r <= stb_s;
         ctl_d_r <= ctl_s;
         if (port_live && stb_edge)
            flag1_r <= 1'b1;
         else if (stat_rd || !port_live)
            flag1_r <= 1'b0;
         if (port_live && !pctl_r[rit_pkg::PCTL_C2OUT] && ctl_edge)
            flag2_r <= 1'b1;
         else if (stat_rd || !port_live)
            flag2_r <= 1'b0;
      end
   end

   // ============================================================
   // timer
   // ============================================================
   logic [7:0]  tctl_r;    // timer control
   logic [7:0]  msb_buf_r; // high byte staging
   logic [15:0] latch_r;   // count reload latch
   logic [15:0] cnt_r;     // down counter
   logic        tflag_r;   // timer underflow flag
   logic        tout_r;    // output toggle state
   logic [2:0]  pre_r;     // prescaler
   logic [rit_pkg::SYNC_STAGES-1:0] ctc_pipe_r;  // strobe-paced sync
   logic [rit_pkg::SYNC_STAGES-1:0] ctg_pipe_r;
   logic        ctc_old_r;  // last recognised external clock level
   logic        ctg_old_r;  // last recognised gate level
   // three strobe periods of sync; a late level is simply caught next strobe
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ctc_pipe_r <= '0;
         ctg_pipe_r <= '0;
         ctc_old_r  <= 1'b0;
         ctg_old_r  <= 1'b0;
      end
      else if (e_rise)
      begin
         ctc_pipe_r <= {ctc_pipe_r[rit_pkg::SYNC_STAGES-2:0], ctc_s};
         ctg_pipe_r <= {ctg_pipe_r[rit_pkg::SYNC_STAGES-2:0], ctg_s};
         ctc_old_r  <= ctc_pipe_r[rit_pkg::SYNC_STAGES-1];
         ctg_old_r  <= ctg_pipe_r[rit_pkg::SYNC_STAGES-1];
      end
   end
   logic ctc_edge, ctg_fall, gate_open;
   assign ctc_edge  = e_rise && (ctc_old_r & ~ctc_pipe_r[rit_pkg::SYNC_STAGES-1]);
   assign ctg_fall  = e_rise && (ctg_old_r & ~ctg_pipe_r[rit_pkg::SYNC_STAGES-1]);
   assign gate_open = !ctg_pipe_r[rit_pkg::SYNC_STAGES-1];
   logic src_tick;  // clock source event
   assign src_tick = tctl_r[rit_pkg::TCTL_EXTCLK] ? ctc_edge : e_rise;
   logic cnt_tick;
   assign cnt_tick = src_tick && (!tctl_r[rit_pkg::TCTL_PRE8] || pre_r == rit_pkg::PRE_LAST)
                     && (!tctl_r[rit_pkg::TCTL_GATED] || gate_open);
   logic lat_wr;
   assign lat_wr = wr_cyc && rsel == rit_pkg::SEL_TLSB;
   // control, staging buffer and reload latch
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         tctl_r    <= rit_pkg::TCTL_RST;
         msb_buf_r <= 8'h00;
         latch_r   <= rit_pkg::LATCH_RST;
      end
      else if (wr_cyc)
      begin
         if (rsel == rit_pkg::SEL_TCTL)
            tctl_r <= HOST_DATA_LINES_IN;
         if (rsel == rit_pkg::SEL_TMSB)
            msb_buf_r <= HOST_DATA_LINES_IN;
         if (lat_wr)
            latch_r <= {msb_buf_r, HOST_DATA_LINES_IN};  // soft reset never touches it
      end
   end

   // counter, prescaler, flag and output
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cnt_r   <= rit_pkg::LATCH_RST;
         pre_r   <= 3'h0;
         tflag_r <= 1'b0;
         tout_r  <= 1'b0;
      end
      else if (tctl_r[rit_pkg::TCTL_SRST] || lat_wr || (!tctl_r[rit_pkg::TCTL_GATED] && ctg_fall))
      begin
         cnt_r   <= lat_wr ? {msb_buf_r, HOST_DATA_LINES_IN} : latch_r;
         pre_r   <= 3'h0;
         tflag_r <= 1'b0;
         tout_r  <= 1'b0;
      end
      else
      begin
         if (src_tick)
            pre_r <= pre_r + 3'h1;
         if (cnt_tick)
         begin
            if (cnt_r == 16'h0000)
            begin
               cnt_r   <= latch_r;
               tflag_r <= 1'b1;
               tout_r  <= ~tout_r;
            end
            else
               cnt_r <= cnt_r - 16'h0001;
         end
         else if (stat_rd)
            tflag_r <= 1'b0;
      end
   end

   // ============================================================
   // read mux and pin drivers
   // ============================================================
   logic [7:0] status_v, rd_v;
   logic irq_any;  // enabled timer or strobe request, or control line flag, pending
   assign status_v = {irq_any, 4'h0, flag2_r, flag1_r, tflag_r};
   assign irq_any = (tflag_r & tctl_r[rit_pkg::TCTL_IEN])
                  | (flag1_r & pctl_r[rit_pkg::PCTL_S1IEN]) | flag2_r;
   always_comb
   begin
      case (rsel)
         rit_pkg::SEL_STATUS_A, rit_pkg::SEL_STATUS_B: rd_v = status_v;
         rit_pkg::SEL_PCTL:  rd_v = pctl_r;
         rit_pkg::SEL_DDIR:  rd_v = ddir_r;
         rit_pkg::SEL_PDATA: rd_v = (pdata_r & ddir_r) | ((pctl_r[rit_pkg::PCTL_LATCH] ? pdata_r : pin_s) & ~ddir_r);
         rit_pkg::SEL_TCTL:  rd_v = tctl_r;
         rit_pkg::SEL_TMSB:  rd_v = cnt_r[15:8];
         rit_pkg::SEL_TLSB:  rd_v = cnt_r[7:0];
         default:            rd_v = 8'h00;
      endcase
   end

   // all outputs registered
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         HOST_DATA_LINES_OUT   <= 8'h00;
         HOST_DATA_LINES_OE    <= 1'b0;
         IRQ_N_OE              <= 1'b0;
         PERIPHERAL_LINES_OUT  <= 8'h00;
         PERIPHERAL_LINES_OE   <= 8'h00;
         PORT_CONTROL_LINE_OUT <= 1'b0;
         PORT_CONTROL_LINE_OE  <= 1'b0;
         TIMER_OUTPUT_PIN      <= 1'b0;
      end
      else
      begin
         HOST_DATA_LINES_OE  <= e_s && rw_s && (rom_sel || io_sel);
         HOST_DATA_LINES_OUT <= rom_sel ? rom_q : rd_v;
         IRQ_N_OE            <= irq_any;  // output low only, never high
         PERIPHERAL_LINES_OUT <= pdata_r;
         PERIPHERAL_LINES_OE  <= ddir_r;
         PORT_CONTROL_LINE_OUT <= pctl_r[rit_pkg::PCTL_C2LVL];
         PORT_CONTROL_LINE_OE  <= port_live && pctl_r[rit_pkg::PCTL_C2OUT];
         TIMER_OUTPUT_PIN <= tctl_r[rit_pkg::TCTL_OEN] && tout_r
                             && (!tctl_r[rit_pkg::TCTL_GATED] || gate_open);
      end
   end

   // ============================================================
   // checks
   // ============================================================
   ddr_reset_a: assert property (@(posedge CLOCK) $rose(ARST_N) |-> PERIPHERAL_LINES_OE == 8'h00)
      else $error("direction not cleared by reset");
   data_hiz_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      !($past(rom_sel) || $past(io_sel)) |-> !HOST_DATA_LINES_OE)
      else $error("data driven while unselected");
   dir_follow_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      ##1 PERIPHERAL_LINES_OE == $past(ddir_r))
      else $error("port enable not following direction");
   irq_wire_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      $rose(flag1_r) && pctl_r[0] |=> IRQ_N_OE)
      else $error("interrupt not pulled low");
   flag_set_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      port_live && stb_edge |=> flag1_r)
      else $error("strobe flag missed");
   latch_cap_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      port_live && pctl_r[4] && stb_edge |=> pdata_r == $past(pin_s))
      else $error("latched input not captured");
   soft_keep_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      tctl_r[0] && !lat_wr |=> $stable(latch_r))
      else $error("soft reset changed latch");
   write_cap_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      wr_cyc && rsel == 3'h2 |=> ddir_r == $past(HOST_DATA_LINES_IN))
      else $error("write not captured on strobe fall");
   read_cov: cover property (@(posedge CLOCK) HOST_DATA_LINES_OE && io_sel);
   rom_cov: cover property (@(posedge CLOCK) HOST_DATA_LINES_OE && rom_sel);
   wrap_cov: cover property (@(posedge CLOCK) tflag_r);
endmodule : rit_top
`default_nettype wire

// ==== verification/rit_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host processor model: free-running strobe, one cycle task
// ============================================================
module rit_host_model (
   input  wire logic        clock,  // system clock
   output logic             strobe, // bus phase strobe
   output logic             valid_memory_access,    // cycle qualifier
   output logic             rnw,    // high read, low write
   output logic [1:0]       sel,    // selects {one,zero}
   output logic [10:0]      addr,   // host address
   input  wire logic [7:0]  dout,   // device data
   input  wire logic        doe,    // device drives the bus
   output logic [7:0]       din     // resolved bus level
);
   logic [3:0] ph_r = 4'h0;   // strobe phase, 16 clocks a period
   logic [7:0] wd   = 8'h00;  // host write data
   logic       wen  = 1'b0;   // host drives the bus
   logic [7:0] last = 8'h00;  // last bus level
   initial
   begin
      valid_memory_access = 1'b0;
      rnw = 1'b1;
      sel = 2'h0;
      addr = 11'h000;
   end
   // strobe runs free, high in the upper half of the phase
   always @(posedge clock) ph_r <= ph_r + 4'h1;
   assign #1 strobe = ph_r[3];
   // a floating bus shows a changing pattern, never a held value
   always @(posedge clock) last <= din;
   assign din = doe ? dout : (wen ? wd : ~last);
   // one cycle: set up 5 clocks after strobe falls, hold 5 after the next fall
   task automatic cyc(input logic r, input logic [1:0] s, input logic [10:0] a,
                      input logic [7:0] w, output logic [7:0] rd, output logic oe);
      do begin @(posedge clock); #2; end while (ph_r != 4'h5);
      valid_memory_access = 1'b1;
      rnw = r;     // direction set by the host
      sel = s;
      addr = a;
      wd = w;
      wen = ~r;    // host drives only on writes
      do begin @(posedge clock); #2; end while (ph_r != 4'hF);
      rd = din;
      oe = doe;
      do begin @(posedge clock); #2; end while (ph_r != 4'h5);
      valid_memory_access = 1'b0;
      wen = 1'b0;
   endtask : cyc
endmodule : rit_host_model
`default_nettype wire

// ==== verification/rom_io_timer_bus_interface_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-checking bench for the rom / port / timer block
// ============================================================
module rom_io_timer_bus_interface_bench;
   localparam logic [1:0] ROM = 2'h1; // rom select pattern
   localparam logic [1:0] IO  = 2'h2; // register select pattern
   logic        clock = 1'b0, arst_n = 1'b0; // clock, reset
   logic        strobe, valid_memory_access, rnw, doe, irq_oe, oe; // bus control
   logic [1:0]  sel;                  // chip selects
   logic [10:0] addr;                 // host address
   logic [7:0]  din, dout, rd, v;     // bus, read result, random byte
   logic [7:0]  p_in, p_out, p_oe, p_drv = 8'h00; // port pins
   logic        s1 = 1'b0, c2_in, c2_out, c2_oe, c2_drv = 1'b0; // handshake
   logic        tclk = 1'b1, tgate = 1'b1, tout; // timer pins
   integer      seed = 54638;         // fixed seed
   int          bad_count = 0, samples_checked = 0; // verdict counts
   always #10 clock = ~clock;
   // pin levels from all drivers; inputs have no pull-up
   assign p_in  = (p_oe & p_out) | (~p_oe & p_drv);
   assign c2_in = c2_oe ? c2_out : c2_drv;
   rit_host_model host (.clock(clock), .strobe(strobe), .valid_memory_access(valid_memory_access), .rnw(rnw), .sel(sel),
                        .addr(addr), .dout(dout), .doe(doe), .din(din));
   rit_top #(.ROM_SEL(ROM), .IO_SEL(IO), .UPPER_Q(8'h00)) dut (
      .CLOCK(clock), .ARST_N(arst_n), .BUS_STROBE(strobe), .VALID_MEMORY_ACCESS(valid_memory_access),
      .READ_NOT_WRITE(rnw), .SELECT_INPUT_ZERO(sel[0]), .SELECT_INPUT_ONE(sel[1]),
      .HOST_ADDRESS_LINES(addr), .HOST_DATA_LINES_IN(din), .HOST_DATA_LINES_OUT(dout),
      .HOST_DATA_LINES_OE(doe), .IRQ_N_OE(irq_oe), .PERIPHERAL_LINES_IN(p_in),
      .PERIPHERAL_LINES_OUT(p_out), .PERIPHERAL_LINES_OE(p_oe), .PORT_STROBE_INPUT(s1),
      .PORT_CONTROL_LINE_IN(c2_in), .PORT_CONTROL_LINE_OUT(c2_out),
      .PORT_CONTROL_LINE_OE(c2_oe), .TIMER_EXTERNAL_CLOCK(tclk),
      .TIMER_GATE_INPUT(tgate), .TIMER_OUTPUT_PIN(tout));
   // ============================================================
   // checking and bus helpers
   // ============================================================
   task automatic chk8(input string what, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask : chk8
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic wr(input logic [2:0] r, input logic [7:0] d);
      host.cyc(1'b0, IO, {8'h00, r}, d, rd, oe);
   endtask : wr
   // register read; the device must drive during it
   task automatic rdv(input logic [2:0] r);
      host.cyc(1'b1, IO, {8'h00, r}, 8'h00, rd, oe);
      chk8("read drive", {7'h0, oe}, 8'h01);
   endtask : rdv
   task automatic rdchk(input string what, input logic [2:0] r, input logic [7:0] e);
      rdv(r);
      chk8(what, rd, e);
   endtask : rdchk
   // bounded wait for the request line, then compare it
   task automatic irq_wait(input logic e);
      for (int i = 0; i < 40 && irq_oe !== e; i++)
      begin
         @(posedge clock);
         #2;
      end
      chk8("irq", {7'h0, irq_oe}, {7'h0, e});
   endtask : irq_wait
   // external clock, each level held two strobe periods
   task automatic ticks(input int n);
      repeat (n)
      begin
         repeat (32) @(posedge clock);
         #2 tclk = 1'b0;
         repeat (32) @(posedge clock);
         #2 tclk = 1'b1;
      end
      repeat (80) @(posedge clock);
   endtask : ticks
   task automatic edge_in(input logic lvl, input logic ctl);
      repeat (32) @(posedge clock);
      #2;
      if (ctl) c2_drv = lvl;
      else s1 = lvl;
      repeat (32) @(posedge clock);
      #2;
   endtask : edge_in
   // watchdog: a hang counts against the run
   initial
   begin
      repeat (90000) @(posedge clock);
      bad_count++;
      test_done();
   end
   // ============================================================
   // main sequence
   // ============================================================
   initial
   begin
      repeat (10) @(posedge clock);
      #2 arst_n = 1'b1;
      chk8("idle", {doe, irq_oe, c2_oe, tout, 4'h0}, 8'h00);
      chk8("port oe", p_oe, 8'h00);
      repeat (4) @(posedge clock);
      rdchk("pctl", rit_pkg::SEL_PCTL, 8'h80);
      rdchk("tctl", rit_pkg::SEL_TCTL, 8'h01);
      rdchk("ddir", rit_pkg::SEL_DDIR, 8'h00);
      rdchk("cnt hi", rit_pkg::SEL_TMSB, 8'hFF);
      rdchk("cnt lo", rit_pkg::SEL_TLSB, 8'hFF);
      rdchk("status", rit_pkg::SEL_STATUS_B, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         host.cyc(1'b1, ROM, (i == 0) ? 11'h7FF : 11'($random(seed)), 8'h00, rd, oe);
         chk8("rom", rd, 8'h00);
         chk8("rom drive", {7'h0, oe}, 8'h01);
      end
      // not selected, wrong upper bits, or writing: bus stays off
      host.cyc(1'b1, 2'h0, 11'h002, 8'h00, rd, oe);
      chk8("unsel", {7'h0, oe}, 8'h00);
      host.cyc(1'b1, 2'h3, 11'h002, 8'h00, rd, oe);
      chk8("unsel", {7'h0, oe}, 8'h00);
      host.cyc(1'b1, IO, 11'h0FA, 8'h00, rd, oe);
      chk8("upper", {7'h0, oe}, 8'h00);
      host.cyc(1'b0, IO, 11'h0FA, 8'h5A, rd, oe);
      host.cyc(1'b0, ROM, 11'h002, 8'h5A, rd, oe);
      chk8("wr drive", {7'h0, oe}, 8'h00);
      rdchk("ddir kept", rit_pkg::SEL_DDIR, 8'h00);
      $display("test select done");
      wr(rit_pkg::SEL_PCTL, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         v = 8'($random(seed));
         wr(rit_pkg::SEL_DDIR, v);
         rdchk("ddir", rit_pkg::SEL_DDIR, v);
         chk8("port oe", p_oe, v);
         wr(rit_pkg::SEL_PDATA, ~v ^ 8'(i));
         chk8("port out", p_out & v, (~v ^ 8'(i)) & v);
      end
      wr(rit_pkg::SEL_DDIR, 8'h00);
      wr(rit_pkg::SEL_STATUS_A, 8'hFF);
      rdchk("status ro", rit_pkg::SEL_STATUS_A, 8'h00);
      $display("test registers done");
      // strobe flag: falling edge, then rising edge with interrupt
      edge_in(1'b1, 1'b0);
      edge_in(1'b0, 1'b0);
      rdv(rit_pkg::SEL_STATUS_A);
      chk8("s1 fall", rd & 8'h7F, 8'h02);
      wr(rit_pkg::SEL_PCTL, 8'h03);
      edge_in(1'b1, 1'b0);
      irq_wait(1'b1);
      rdchk("s1 rise", rit_pkg::SEL_STATUS_B, 8'h82);
      irq_wait(1'b0);
      edge_in(1'b0, 1'b0);
      rdv(rit_pkg::SEL_STATUS_A);
      chk8("s1 wrong edge", rd & 8'h7F, 8'h00);
      // latched input keeps the value present at the strobe
      wr(rit_pkg::SEL_PCTL, 8'h12);
      p_drv = 8'($random(seed));
      v = p_drv;
      edge_in(1'b1, 1'b0);
      p_drv = ~v;
      rdchk("latched", rit_pkg::SEL_PDATA, v);
      rdv(rit_pkg::SEL_STATUS_A);
      // control line as output, then as edge input
      wr(rit_pkg::SEL_PCTL, 8'h28);
      chk8("c2 out", {6'h0, c2_oe, c2_out}, 8'h03);
      wr(rit_pkg::SEL_PCTL, 8'h20);
      chk8("c2 out", {6'h0, c2_oe, c2_out}, 8'h02);
      wr(rit_pkg::SEL_PCTL, 8'h04);
      chk8("c2 in", {7'h0, c2_oe}, 8'h00);
      edge_in(1'b1, 1'b1);
      rdv(rit_pkg::SEL_STATUS_A);
      chk8("c2 flag", rd & 8'h7F, 8'h04);
      $display("test port done");
      // timer: latch 5, external clock, interrupt and output on
      wr(rit_pkg::SEL_TMSB, 8'h00);
      wr(rit_pkg::SEL_TLSB, 8'h05);
      wr(rit_pkg::SEL_TCTL, 8'hC2);
      rdchk("tctl", rit_pkg::SEL_TCTL, 8'hC2);
      ticks(3);
      rdchk("cnt hi", rit_pkg::SEL_TMSB, 8'h00);
      rdchk("cnt lo", rit_pkg::SEL_TLSB, 8'h02);
      ticks(4);
      irq_wait(1'b1);
      chk8("tout", {7'h0, tout}, 8'h01);
      rdv(rit_pkg::SEL_STATUS_A);
      chk8("t flag", rd & 8'h81, 8'h81);
      irq_wait(1'b0);
      // prescaled external clock: eight slow edges make one count
      wr(rit_pkg::SEL_TLSB, 8'h05);
      wr(rit_pkg::SEL_TCTL, 8'h06);
      ticks(8);
      rdchk("pre8", rit_pkg::SEL_TLSB, 8'h04);
      // gate falling edge reloads, then the gate level gates the clock
      tgate = 1'b0;
      repeat (80) @(posedge clock);
      rdchk("gate load", rit_pkg::SEL_TLSB, 8'h05);
      wr(rit_pkg::SEL_TCTL, 8'h0A);
      ticks(1);
      rdchk("gate open", rit_pkg::SEL_TLSB, 8'h04);
      #2 tgate = 1'b1;
      ticks(1);
      rdchk("gate shut", rit_pkg::SEL_TLSB, 8'h04);
      $display("test timer done");
      test_done();
   end
endmodule : rom_io_timer_bus_interface_bench
`default_nettype wire
